// ### hw/link_event_defines.svh
// Offsets, bit positions and timing counts for the upper event flags
`ifndef LINK_EVENT_DEFINES_SVH
`define LINK_EVENT_DEFINES_SVH
`define EV_SET_OFFSET 8'h80
`define EV_CLR_OFFSET 8'h84
`define EV_BIT_REG_BYTE 26
`define EV_BIT_OVERLONG 25
`define EV_BIT_FATAL 24
`define EV_BIT_MISMATCH 23
`define EV_BIT_MISSED 22
`define EV_BIT_SEC_CHANGE 21
`define EV_BIT_NEW_CYCLE 20
`define EV_BIT_LINE_REQ 19
`define EV_BIT_REINIT 17
`define EV_BIT_ID_DONE 16
`define EV_IMPL_MASK 16'h07fb
`define SEC_WATCH_BIT 6
`define OVERLONG_MIN_US 115
`define OVERLONG_MAX_US 120
`define CLK_MHZ 50
`define OVERLONG_MIN_CYC ((`OVERLONG_MIN_US) * (`CLK_MHZ))
`define OVERLONG_MAX_CYC ((`OVERLONG_MAX_US) * (`CLK_MHZ))
`define OVERLONG_CNT_W 13
`endif

// ### hw/link_event_pkg.sv
// Types shared by the upper event flag block
package link_event_pkg;
  // One cycle event pulses from the link logic
  typedef struct packed {
    logic reg_byte;
    logic fatal;
    logic mismatch_rx;
    logic line_req;
    logic reinit;
    logic id_stream_end;
    logic cycle_start_seen;
    logic cycle_start_sent;
    logic subaction_gap;
  } link_events_s;
  // Overlong cycle watchdog states
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN = 2'b01,
    WD_FIRE = 2'b11
  } wd_state_e;
endpackage

// ### hw/overlong_timer.sv
// Overlong isochronous cycle watchdog
`timescale 1ns/10ps
`include "link_event_defines.svh"
module overlong_timer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic cancel_i,
  output logic fire_o
);
  link_event_pkg::wd_state_e state_r;
  logic [`OVERLONG_CNT_W-1:0] count_r;
  // Fire at the least time, inside the window
  localparam logic [`OVERLONG_CNT_W-1:0] FIRE_AT = `OVERLONG_CNT_W'(`OVERLONG_MIN_CYC);

  // Count from cycle start; gap or reset cancels
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= link_event_pkg::WD_IDLE;
      count_r <= '0;
      fire_o <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      case (state_r)
        link_event_pkg::WD_IDLE: begin
          count_r <= '0;
          if (start_i) begin
            state_r <= link_event_pkg::WD_RUN;
          end
        end
        link_event_pkg::WD_RUN: begin
          if (cancel_i) begin
            state_r <= link_event_pkg::WD_IDLE;
          end else if (count_r == FIRE_AT - 1'b1) begin
            state_r <= link_event_pkg::WD_FIRE; // RL3
          end else begin
            count_r <= count_r + 1'b1;
          end
        end
        link_event_pkg::WD_FIRE: begin
          fire_o <= 1'b1;
          state_r <= link_event_pkg::WD_IDLE;
        end
        default: begin
          state_r <= link_event_pkg::WD_IDLE;
        end
      endcase
    end
  end
endmodule

// ### hw/link_event_flags_upper.sv
// Upper half of the interrupt event register with set and clear views
// Notes on behaviour
// (RL1) Line chip register byte arrival sets bit 26
// (RL2) Overlong cycle sets bit 25 when originating
// (RL3) Overlong timer fires 115 to 120 us
// (RL4) Overlong event clears cycle originator enable
// (RL5) Subunit halting error sets bit 24
// (RL6) Fatal flag blocks offending contexts' interrupts
// (RL7) Received cycle start mismatch sets bit 23
// (RL8) Host write to timer fields sets 23; the code sets it only when the write changed sec or count
// (RL9) No cycle start between ticks sets 22
// (RL10) Seconds counter bit 6 change sets 21
// (RL11) Cycle count LSB toggle sets 20
// (RL12) Line chip status interrupt sets bit 19
// (RL13) Line chip bus reset sets bit 17
// (RL14) Self-ID end sets 16 if capture enabled
// (RL15) Bus reset flag set clears bit 16
// (RL16) Set/clear by writing ones; zeros ignored
// (RL17) Set view raw, clear view masked
// (RL18) Interrupt when any enabled flag set
// (RL19) Bus reset clear ignored during self-ID
// (RL20) Reserved bits read zero, writes ignored
`timescale 1ns/10ps
`include "link_event_defines.svh"
module link_event_flags_upper (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i, // Byte offset of access
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  input wire logic [31:0] reg_wdata_i, // Write data
  output logic [31:0] reg_rdata_o, // Read data, registered
  input wire logic [15:0] interrupt_enable_mask_i, // Mask bits 31:16
  input wire link_event_pkg::link_events_s events_i, // Source pulses
  input wire logic selfid_phase_i, // Self-ID phase in progress
  input wire logic capture_id_packets_enable_i, // Link settings bit 9
  input wire logic cycle_originator_set_i, // Software sets originator enable
  input wire logic cycle_originator_clr_i, // Software clears originator enable
  input wire logic [6:0] cycle_timer_sec_field_i, // Running seconds count
  input wire logic [12:0] cycle_timer_cnt_field_i, // Running cycle count
  input wire logic timer_host_write_i, // Host wrote the cycle timer
  input wire logic timer_host_changed_i, // That write changed sec or count
  input wire logic ctx_event_i, // Normal context interrupt request
  input wire logic ctx_is_culprit_i, // That context caused the fatal halt
  output logic ctx_event_o, // Context interrupt passed on
  output logic cycle_originator_enable_o, // Link settings bit 21
  output logic irq_o // Processor interrupt
);
  logic [15:0] interrupt_event_reg; // Flags for bits 31:16
  logic [15:0] hw_set; // Hardware set terms this cycle
  logic [15:0] sw_set; // Software set terms
  logic [15:0] sw_clr; // Software clear terms
  logic [15:0] ev_nxt;
  logic sec_bit_r; // Last watched seconds bit
  logic cnt_lsb_r; // Last cycle count lsb
  logic tick_primed_r; // A first tick has been seen
  logic start_since_tick_r; // Cycle start seen since last tick
  logic new_tick;
  logic overlong_fire;
  logic wr_set;
  logic wr_clr;

  // Watchdog starts on a sent start while idle, ignores later ones; gap or reset stop it
  overlong_timer u_overlong (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(events_i.cycle_start_sent),
    .cancel_i(events_i.subaction_gap | events_i.reinit),
    .fire_o(overlong_fire)
  );

  // Address decode of the two views
  always_comb begin
    wr_set = 1'b0;
    wr_clr = 1'b0;
    if (reg_wr_i && reg_addr_i == `EV_SET_OFFSET) begin
      wr_set = 1'b1;
    end else if (reg_wr_i && reg_addr_i == `EV_CLR_OFFSET) begin
      wr_clr = 1'b1;
    end
  end

  assign new_tick = cycle_timer_cnt_field_i[0] ^ cnt_lsb_r;

  // Edge trackers for the timer fields
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sec_bit_r <= 1'b0;
      cnt_lsb_r <= 1'b0;
    end else begin
      sec_bit_r <= cycle_timer_sec_field_i[`SEC_WATCH_BIT];
      cnt_lsb_r <= cycle_timer_cnt_field_i[0];
    end
  end

  // Lost cycle tracker between consecutive ticks
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tick_primed_r <= 1'b0;
      start_since_tick_r <= 1'b0;
    end else if (new_tick) begin
      tick_primed_r <= 1'b1;
      start_since_tick_r <= events_i.cycle_start_seen | events_i.cycle_start_sent;
    end else if (events_i.cycle_start_seen || events_i.cycle_start_sent) begin
      start_since_tick_r <= 1'b1;
    end
  end

  // Hardware set sources
  always_comb begin
    hw_set = 16'h0000;
    hw_set[`EV_BIT_REG_BYTE-16] = events_i.reg_byte; // RL1
    hw_set[`EV_BIT_OVERLONG-16] = overlong_fire & cycle_originator_enable_o; // RL2
    hw_set[`EV_BIT_FATAL-16] = events_i.fatal; // RL5
    hw_set[`EV_BIT_MISMATCH-16] = events_i.mismatch_rx // RL7
      | (timer_host_write_i & timer_host_changed_i); // RL8
    hw_set[`EV_BIT_MISSED-16] = new_tick & tick_primed_r & ~start_since_tick_r; // RL9
    hw_set[`EV_BIT_SEC_CHANGE-16] = cycle_timer_sec_field_i[`SEC_WATCH_BIT] ^ sec_bit_r; // RL10
    hw_set[`EV_BIT_NEW_CYCLE-16] = new_tick; // RL11
    hw_set[`EV_BIT_LINE_REQ-16] = events_i.line_req; // RL12
    hw_set[`EV_BIT_REINIT-16] = events_i.reinit; // RL13
    hw_set[`EV_BIT_ID_DONE-16] = events_i.id_stream_end & capture_id_packets_enable_i; // RL14
  end

  // Software set and clear terms, reserved bits masked off
  always_comb begin
    sw_set = wr_set ? (reg_wdata_i[31:16] & `EV_IMPL_MASK) : 16'h0000; // RL16 RL20
    sw_clr = wr_clr ? (reg_wdata_i[31:16] & `EV_IMPL_MASK) : 16'h0000; // RL16 RL20
    if (selfid_phase_i) begin
      sw_clr[`EV_BIT_REINIT-16] = 1'b0; // RL19
    end
  end

  // Set wins over clear; bus reset entry forces self-ID done low
  always_comb begin
    ev_nxt = (interrupt_event_reg & ~sw_clr) | hw_set | sw_set;
    if (hw_set[`EV_BIT_REINIT-16]) begin
      ev_nxt[`EV_BIT_ID_DONE-16] = 1'b0; // RL15
    end
  end

  // Event flags; reset value is a defined zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      interrupt_event_reg <= 16'h0000;
    end else begin
      interrupt_event_reg <= ev_nxt; // RL16
    end
  end

  // Originator enable, dropped by the overlong event
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cycle_originator_enable_o <= 1'b0;
    end else if (overlong_fire && cycle_originator_enable_o) begin
      cycle_originator_enable_o <= 1'b0; // RL4
    end else if (cycle_originator_set_i) begin
      cycle_originator_enable_o <= 1'b1;
    end else if (cycle_originator_clr_i) begin
      cycle_originator_enable_o <= 1'b0;
    end
  end

  // Context interrupts gated while their fatal halt is flagged
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctx_event_o <= 1'b0;
    end else begin
      ctx_event_o <= ctx_event_i & ~(ctx_is_culprit_i & interrupt_event_reg[`EV_BIT_FATAL-16]); // RL6
    end
  end

  // Read views; one cycle latency
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i && reg_addr_i == `EV_SET_OFFSET) begin
      reg_rdata_o <= {interrupt_event_reg, 16'h0000}; // RL17
    end else if (reg_rd_i && reg_addr_i == `EV_CLR_OFFSET) begin
      reg_rdata_o <= {interrupt_event_reg & interrupt_enable_mask_i, 16'h0000}; // RL17
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // Interrupt registered from the next flags, changing in the same cycle as them
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(ev_nxt & interrupt_enable_mask_i); // RL18
    end
  end

  // Checks
  sw_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_set && reg_wdata_i[`EV_BIT_LINE_REQ] |=> interrupt_event_reg[`EV_BIT_LINE_REQ-16]) // RL16
    else $error("Set write did not set flag");
  reinit_clr_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    events_i.reinit |=> interrupt_event_reg[`EV_BIT_REINIT-16] && !interrupt_event_reg[`EV_BIT_ID_DONE-16]) // RL15
    else $error("Bus reset entry did not clear id done");
  clr_block_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    selfid_phase_i && interrupt_event_reg[`EV_BIT_REINIT-16] |=> interrupt_event_reg[`EV_BIT_REINIT-16]) // RL19
    else $error("Bus reset flag cleared during self-ID");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    interrupt_event_reg[2] == 1'b0 && interrupt_event_reg[15:11] == 5'h00) // RL20
    else $error("Reserved bit set");
  irq_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 irq_o == |(interrupt_event_reg & $past(interrupt_enable_mask_i))) // RL18
    else $error("Interrupt does not match enabled flags");
  masked_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == `EV_CLR_OFFSET |=>
    reg_rdata_o[31:16] == ($past(interrupt_event_reg) & $past(interrupt_enable_mask_i))) // RL17
    else $error("Masked read wrong");
  overlong_drop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    overlong_fire && cycle_originator_enable_o |=> !cycle_originator_enable_o
    && interrupt_event_reg[`EV_BIT_OVERLONG-16]) // RL4
    else $error("Overlong did not drop originator");
  tick_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $changed(cycle_timer_cnt_field_i[0]) |=> interrupt_event_reg[`EV_BIT_NEW_CYCLE-16]) // RL11
    else $error("New cycle flag missed");
  fatal_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ctx_is_culprit_i && interrupt_event_reg[`EV_BIT_FATAL-16] |=> !ctx_event_o) // RL6
    else $error("Blocked context interrupt passed");
  cov_irq_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(irq_o));
  cov_over_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) overlong_fire);
  cov_lost_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) hw_set[`EV_BIT_MISSED-16]);
endmodule

// ### tb/link_event_flags_upper_tb.sv
// Self-checking bench for the upper interrupt event flags
`timescale 1ns/10ps
module link_event_flags_upper_tb;
  logic clk_i = 1'b0; // 50 MHz clock
  logic reset_n_i = 1'b0; // Sync reset, active low
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic [15:0] mask = 16'hffff; // Enable mask for bits 31:16
  logic [8:0] ev = 9'h000; // Source pulses, struct order
  logic selfid = 1'b0;
  logic cap_en = 1'b1;
  logic orig_set = 1'b0;
  logic orig_clr = 1'b0;
  logic [6:0] sec = 7'h00;
  logic [12:0] cnt = 13'h0000;
  logic host_wr = 1'b0;
  logic host_chg = 1'b0;
  logic ctx_in = 1'b0;
  logic culprit = 1'b0;
  logic ctx_out, orig_en, irq_o;
  logic [31:0] rd_val; // Last read result
  int errors = 0;
  int n_compared = 0;
  // Source pulses and the flag each one should raise
  logic [8:0] src [5] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010};
  logic [31:0] flag [5] = '{32'h04000000, 32'h01000000, 32'h00800000, 32'h00080000, 32'h00020000};

  link_event_flags_upper dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .interrupt_enable_mask_i(mask), .events_i(link_event_pkg::link_events_s'(ev)),
    .selfid_phase_i(selfid), .capture_id_packets_enable_i(cap_en), .cycle_originator_set_i(orig_set),
    .cycle_originator_clr_i(orig_clr), .cycle_timer_sec_field_i(sec), .cycle_timer_cnt_field_i(cnt),
    .timer_host_write_i(host_wr), .timer_host_changed_i(host_chg), .ctx_event_i(ctx_in),
    .ctx_is_culprit_i(culprit), .ctx_event_o(ctx_out), .cycle_originator_enable_o(orig_en), .irq_o(irq_o));

  // Free running clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // Wait n edges, then step just past the edge to drive
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Counted comparison; unknowns never match
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe, then one idle edge so the next strobe never rises in the same step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    step(1);
    reg_wr_i = 1'b0;
    step(1);
  endtask

  // One-cycle read strobe, data registered at that edge
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    step(1);
    reg_rd_i = 1'b0;
    rd_val = reg_rdata_o;
    chk("event read", exp, rd_val);
    step(1);
  endtask

  // Clear every flag through the clear view
  task automatic clr;
    wr(8'h84, 32'hffffffff);
  endtask

  // One-cycle source pulse
  task automatic pulse(input logic [8:0] v);
    ev = v;
    step(1);
    ev = 9'h000;
    step(1);
  endtask

  // Cycle start sent, optionally cancelled by a gap, then watch the timer
  task automatic overlong(input logic gap, input logic [31:0] exp);
    orig_set = 1'b1;
    step(1);
    orig_set = 1'b0;
    pulse(9'h002);
    pulse({8'h00, gap});
    step(5740);
    rchk(8'h80, 32'h0);
    step(20);
    rchk(8'h80, exp);
    chk("originator", {31'h0, gap}, {31'h0, orig_en});
    orig_clr = 1'b1;
    step(1);
    orig_clr = 1'b0;
    clr();
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cuts a hang short, well past the expected run
  initial begin
    #800000;
    errors++;
    $display("watchdog expired");
    conclude();
  end

  // Main sequence
  initial begin
    step(16);
    reset_n_i = 1'b1;
    rchk(8'h80, 32'h0);
    // Software set, reserved bits stay zero
    wr(8'h80, 32'hffffffff);
    rchk(8'h80, 32'h07fb0000);
    mask = 16'h0001;
    rchk(8'h84, 32'h00010000);
    chk("irq", 32'h1, {31'h0, irq_o});
    mask = 16'h0000;
    rchk(8'h84, 32'h0);
    chk("irq", 32'h0, {31'h0, irq_o});
    mask = 16'hffff;
    wr(8'h84, 32'h00000000);
    wr(8'h84, 32'hf8050000);
    rchk(8'h80, 32'h07fa0000);
    // Bus reset flag survives a clear during self-ID
    selfid = 1'b1;
    clr();
    rchk(8'h80, 32'h00020000);
    selfid = 1'b0;
    clr();
    rchk(8'h80, 32'h0);
    // Each plain source sets its own flag
    for (int i = 0; i < 5; i++) begin
      pulse(src[i]);
      rchk(8'h80, flag[i]);
      clr();
    end
    // Self-ID end, then bus reset wipes it
    pulse(9'h008);
    rchk(8'h80, 32'h00010000);
    pulse(9'h010);
    rchk(8'h80, 32'h00020000);
    clr();
    cap_en = 1'b0;
    pulse(9'h008);
    rchk(8'h80, 32'h0);
    // Host timer writes: only a real change counts
    host_wr = 1'b1;
    step(1);
    host_wr = 1'b0;
    rchk(8'h80, 32'h0);
    host_wr = 1'b1;
    host_chg = 1'b1;
    step(1);
    host_wr = 1'b0;
    host_chg = 1'b0;
    rchk(8'h80, 32'h00800000);
    clr();
    // Fatal flag gates only the offending context
    pulse(9'h080);
    ctx_in = 1'b1;
    culprit = 1'b1;
    step(2);
    chk("ctx event", 32'h0, {31'h0, ctx_out});
    culprit = 1'b0;
    step(2);
    chk("ctx event", 32'h1, {31'h0, ctx_out});
    clr();
    culprit = 1'b1;
    step(2);
    chk("ctx event", 32'h1, {31'h0, ctx_out});
    ctx_in = 1'b0;
    // Cycle ticks, with and without a cycle start between them
    cnt = 13'h0001;
    step(2);
    rchk(8'h80, 32'h00100000);
    clr();
    pulse(9'h004);
    cnt = 13'h0000;
    step(2);
    rchk(8'h80, 32'h00100000);
    clr();
    cnt = 13'h0001;
    step(2);
    rchk(8'h80, 32'h00500000);
    clr();
    // Only seconds bit 6 raises the long tick
    sec = 7'h01;
    step(2);
    rchk(8'h80, 32'h0);
    sec = 7'h41;
    step(2);
    rchk(8'h80, 32'h00200000);
    clr();
    // Overlong watchdog, fired and cancelled
    overlong(1'b0, 32'h02000000);
    overlong(1'b1, 32'h0);
    conclude();
  end
endmodule
